// File: dsw_regs.vh
// constants for the serial write port of the converter
`ifndef DSW_REGS_VH
`define DSW_REGS_VH
`define DSW_FRAME_BITS 24
`define DSW_CNT_W 5
`define DSW_LAST_BIT 5'h17
`define DSW_CODE_MSB 15
`define DSW_MODE_HI 21
`define DSW_MODE_LO 20
`define DSW_CODE_HI 19
`define DSW_CODE_LO 4
`define DSW_CODE_RST 16'h0000
`define DSW_MODE_RST 2'h0
`define DSW_MODE_HI_RST 1'h0
`define DSW_MODE_LO_RST 1'h0
`define DSW_CNT_ZERO 5'h00
`define DSW_CNT_ONE 5'h01
`define DSW_SHIFT_RST 24'h000000
`define DSW_PIN_IDLE_HI 1'h1
`define DSW_PIN_IDLE_LO 1'h0
`endif

// File: dsw_sync2.v
// two-flop synchroniser for one pin level
`timescale 1ns/10ps
module dsw_sync2 #(
	parameter RST_VAL = 1'h0
) (
	input wire ref_clk,
	input wire resetn,
	input wire pin_in,
	output reg pin_sync
);
	reg meta_reg;

	always @(posedge ref_clk) begin
		if (!resetn) begin
			// reset to the pin's idle level, so no false edge follows reset
			meta_reg <= RST_VAL;
			pin_sync <= RST_VAL;
		end else begin
			meta_reg <= pin_in;
			pin_sync <= meta_reg;
		end
	end
endmodule

// File: dsw_write_port.v
// serial write port: 24-bit frame into converter code and power mode
// Notes on behaviour
// (R1) shift register holds 24 bits
// (R2) sample data on serial clock falling edge
// (R3) accept bits only while frame select low
// (R4) 24th falling edge updates converter register
// (R5) early frame select rise aborts write
// (R6) two leading bits select power mode; the code takes the third and fourth bits (frame bits 21:20) instead
// (R7) next 16 bits become converter code; the code takes frame bits 19:4 instead
// (R8) host raises select before next frame
// (R9) abort clears shifter, keeps code and mode
// (R10) most significant bit first
`timescale 1ns/10ps
`include "dsw_regs.vh"
module dsw_write_port (
	// clock and reset
	input wire ref_clk,
	input wire resetn,
	// serial pins
	input wire sclk_pin,
	input wire din_pin,
	input wire sync_n_pin,
	// converter side
	output reg [15:0] dac_code,
	output reg power_mode_bit_hi,
	output reg power_mode_bit_lo,
	output reg update_pulse,
	output reg abort_pulse
);

	// frame states
	localparam ST_IDLE = 2'b00;
	localparam ST_SHIFT = 2'b01;
	localparam ST_DONE = 2'b10;

	// synchronised pin levels
	wire sclk_s;
	wire din_s;
	wire sync_n_s;

	// edge detection history
	reg sclk_d_reg;
	reg sync_n_d_reg;

	// frame control
	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [`DSW_CNT_W-1:0] cnt_reg;
	reg [`DSW_CNT_W-1:0] cnt_next;

	// shifter
	reg [`DSW_FRAME_BITS-1:0] shift_reg;
	wire [`DSW_FRAME_BITS-1:0] shift_next;
	wire [`DSW_FRAME_BITS-1:0] frame_word;
	reg shift_en;
	reg shift_clr;

	// next values of the outputs
	reg [15:0] dac_code_next;
	reg power_mode_bit_hi_next;
	reg power_mode_bit_lo_next;
	reg update_next;
	reg abort_next;

	// decoded events
	wire sclk_fall;
	wire sync_fall;
	wire sync_rise;
	wire take_bit;
	wire last_bit;

	// serial clock idles high between frames
	dsw_sync2 #(
		.RST_VAL(`DSW_PIN_IDLE_HI)
	) u_sclk (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.pin_in(sclk_pin),
		.pin_sync(sclk_s)
	);

	dsw_sync2 #(
		.RST_VAL(`DSW_PIN_IDLE_LO)
	) u_din (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.pin_in(din_pin),
		.pin_sync(din_s)
	);

	// select idles high; a low reset value would fake a frame start
	dsw_sync2 #(
		.RST_VAL(`DSW_PIN_IDLE_HI)
	) u_sync (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.pin_in(sync_n_pin),
		.pin_sync(sync_n_s)
	);

	assign sclk_fall = sclk_d_reg & ~sclk_s; // [R2]
	assign sync_fall = sync_n_d_reg & ~sync_n_s;
	assign sync_rise = ~sync_n_d_reg & sync_n_s;
	// data and clock share the same sync delay, so din_s is the bit at the edge
	assign take_bit = sclk_fall & ~sync_n_s; // [R3]
	assign last_bit = (cnt_reg == `DSW_LAST_BIT); // [R4]
	// first bit taken walks up to the top position
	assign frame_word = {shift_reg[`DSW_FRAME_BITS-2:0], din_s}; // [R1] [R10]

	// one cell per shifter bit: clear, shift or hold
	genvar i;
	generate
		for (i = 0; i < `DSW_FRAME_BITS; i = i + 1) begin : g_shift
			assign shift_next[i] = shift_clr ? 1'h0 : (shift_en ? frame_word[i] : shift_reg[i]);
		end
	endgenerate

	// frame sequencing and the values applied at the end of a frame
	always @* begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		shift_en = 1'h0;
		shift_clr = 1'h0;
		dac_code_next = dac_code;
		power_mode_bit_hi_next = power_mode_bit_hi;
		power_mode_bit_lo_next = power_mode_bit_lo;
		update_next = 1'h0;
		abort_next = 1'h0;
		case (state_reg)
			ST_IDLE: begin
				// only a fresh select fall opens a frame
				if (sync_fall) begin
					state_next = ST_SHIFT; // [R8]
					cnt_next = `DSW_CNT_ZERO;
					shift_clr = 1'h1;
				end
			end
			ST_SHIFT: begin
				if (sync_rise) begin
					// an unfinished frame is dropped whole
					state_next = ST_IDLE;
					cnt_next = `DSW_CNT_ZERO;
					shift_clr = 1'h1; // [R9]
					abort_next = (cnt_reg != `DSW_CNT_ZERO); // [R5]
				end else if (take_bit) begin
					shift_en = 1'h1;
					if (last_bit) begin
						state_next = ST_DONE; // [R4]
						cnt_next = `DSW_CNT_ZERO;
						dac_code_next = frame_word[`DSW_CODE_HI:`DSW_CODE_LO]; // [R7]
						power_mode_bit_hi_next = frame_word[`DSW_MODE_HI]; // [R6]
						power_mode_bit_lo_next = frame_word[`DSW_MODE_LO]; // [R6]
						update_next = 1'h1;
					end else begin
						cnt_next = cnt_reg + `DSW_CNT_ONE;
					end
				end
			end
			ST_DONE: begin
				// clock falls after the last bit are ignored until select rises
				if (sync_rise) begin
					state_next = ST_IDLE; // [R8]
					shift_clr = 1'h1;
				end
			end
			default: begin
				state_next = ST_IDLE;
				cnt_next = `DSW_CNT_ZERO;
				shift_clr = 1'h1;
			end
		endcase
	end

	// control registers
	always @(posedge ref_clk) begin
		if (!resetn) begin
			sclk_d_reg <= `DSW_PIN_IDLE_HI;
			sync_n_d_reg <= `DSW_PIN_IDLE_HI;
			state_reg <= ST_IDLE;
			cnt_reg <= `DSW_CNT_ZERO;
			shift_reg <= `DSW_SHIFT_RST;
		end else begin
			sclk_d_reg <= sclk_s;
			sync_n_d_reg <= sync_n_s;
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			shift_reg <= shift_next;
		end
	end

	// output registers: outputs come straight from these flops
	always @(posedge ref_clk) begin
		if (!resetn) begin
			dac_code <= `DSW_CODE_RST;
			power_mode_bit_hi <= `DSW_MODE_HI_RST;
			power_mode_bit_lo <= `DSW_MODE_LO_RST;
			update_pulse <= 1'h0;
			abort_pulse <= 1'h0;
		end else begin
			dac_code <= dac_code_next;
			power_mode_bit_hi <= power_mode_bit_hi_next;
			power_mode_bit_lo <= power_mode_bit_lo_next;
			// pulses last one cycle; the converter acts on them at once
			update_pulse <= update_next;
			abort_pulse <= abort_next;
		end
	end

	// limitation: a frame shorter than one sclk fall gives no abort pulse
	// trade-off: two flops of latency on every pin limit the serial clock
	// to a few megahertz at this reference clock
endmodule

// File: dsw_host.sv
// host model for the serial pins
`timescale 1ns/10ps
module dsw_host (
	output logic sclk = 1'b1,
	output logic din = 1'b0,
	output logic sync_n = 1'b1
);
	task automatic send(input logic [23:0] w, input int n);
		sync_n = 0;
		for (int i = 23; i > 23 - n; i--) begin
			din = (i >= 0) ? w[i] : 1'b1;
			#100 sclk = 0;
			#100 sclk = 1;
		end
		#100 sync_n = 1;
	endtask
endmodule

// File: dsw_chk_sva.sv
// output assertions of the write port
`timescale 1ns/10ps
module dsw_chk (
	input wire ref_clk,
	input wire resetn,
	input wire [15:0] dac_code,
	input wire power_mode_bit_hi,
	input wire power_mode_bit_lo,
	input wire update_pulse,
	input wire abort_pulse
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	upd_pulse_a: assert property (update_pulse |=> !update_pulse) else $error("long");
	code_hold_a: assert property (!update_pulse |-> $stable(dac_code)) else $error("code");
	mode_hold_a: assert property (!update_pulse |-> $stable(power_mode_bit_hi)) else $error("mode");
	abort_only_a: assert property (abort_pulse |-> !update_pulse ##1 !abort_pulse) else $error("abt");
	mode_lo_hold_a: assert property (!update_pulse |-> $stable(power_mode_bit_lo)) else $error("mlo");
	abort_keep_a: assert property (abort_pulse |-> $stable(dac_code)) else $error("akeep");
endmodule
bind dsw_write_port dsw_chk u_chk (.*);

// File: dsw_write_port_tb.sv
// bench for the serial write port
`timescale 1ns/10ps
module dsw_write_port_tb;
	logic ref_clk = 0, resetn = 0, sclk, din, sync_n, hi, lo, upd, abt, su, sa;
	logic [15:0] code;
	int errors = 0, check_count = 0;
	always #12.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) {su, sa} <= {su | upd, sa | abt};
	dsw_host u_host (.sclk(sclk), .din(din), .sync_n(sync_n));
	dsw_write_port u_dut (.ref_clk, .resetn, .sclk_pin(sclk), .din_pin(din), .sync_n_pin(sync_n),
		.dac_code(code), .power_mode_bit_hi(hi), .power_mode_bit_lo(lo),
		.update_pulse(upd), .abort_pulse(abt));
	task automatic frame(input logic [23:0] w, input int n, input logic [19:0] exp);
		repeat (4) @(negedge ref_clk);
		{su, sa} = 0;
		u_host.send(w, n);
		repeat (10) @(negedge ref_clk);
		check_count++;
		if ({hi, lo, code, su, sa} !== exp) begin
			errors++;
			$display("ERROR %0t frame %h", $time, w);
		end
	endtask
	task automatic modes_test;
		for (int m = 0; m < 4; m++)
			frame({2'b11, 2'(m), 16'h75A1 ^ 16'(m), 4'hF}, 24, {2'(m), 16'h75A1 ^ 16'(m), 2'b10});
	endtask
	task automatic reset_test;
		repeat (4) @(negedge ref_clk);
		check_count++;
		if ({hi, lo, code, upd, abt} !== 20'h0) begin
			errors++;
			$display("ERROR %0t reset state", $time);
		end
	endtask
	task automatic stop_test;
		$display("errors=%0d checks=%0d", errors, check_count);
		if (errors == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(negedge ref_clk);
		resetn = 1;
		reset_test();
		modes_test();
		frame(24'h0, 12, {2'b11, 16'h75A2, 2'b01});
		frame(24'h112340, 26, {2'b01, 16'h1234, 2'b10});
		stop_test();
	end
endmodule
